// file: src/can_cfg_pkg.sv
// constants, types and register map of the controller setup block
package can_cfg_pkg;

	// register port widths
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;

	// register offsets
	localparam logic [7:0] OFS_RX_BUFFER0_CONTROL     = 8'h00;
	localparam logic [7:0] OFS_BUFFER_PIN_CONTROL     = 8'h01;
	localparam logic [7:0] OFS_TX_REQUEST_PIN_CONTROL = 8'h02;
	localparam logic [7:0] OFS_MAIN_CONTROL_REGISTER  = 8'h03;
	localparam logic [7:0] OFS_MODE_STATUS            = 8'h04;
	localparam logic [7:0] OFS_BIT_TIMING_CONFIG_1    = 8'h05;
	localparam logic [7:0] OFS_BIT_TIMING_CONFIG_2    = 8'h06;
	localparam logic [7:0] OFS_BIT_TIMING_CONFIG_3    = 8'h07;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE_MASK  = 8'h08;
	localparam logic [7:0] OFS_INTERRUPT_FLAGS        = 8'h09;

	// rx_buffer0_control fields
	localparam int RX_ROLLOVER_BIT = 2;
	// buffer_pin_control fields
	localparam int BUF1_PIN_LEVEL_BIT = 5;
	localparam int BUF0_PIN_LEVEL_BIT = 4;
	localparam int BUF1_PIN_ENABLE_BIT = 3;
	localparam int BUF0_PIN_ENABLE_BIT = 2;
	localparam int BUF1_PIN_FUNCTION_BIT = 1;
	localparam int BUF0_PIN_FUNCTION_BIT = 0;
	// tx_request_pin_control: mode bits 2..0, pin levels 5..3
	localparam int TX_REQ_MODE_LSB = 0;
	localparam int TX_REQ_LEVEL_LSB = 3;
	// main_control_register fields
	localparam int REQ_OP_LSB = 5;
	localparam int CLK_OUT_ENABLE_BIT = 2;
	localparam int CLK_OUT_PRESCALE_LSB = 0;
	// mode_status field
	localparam int CUR_OP_LSB = 5;
	// bit timing fields
	localparam int JUMP_WIDTH_LSB = 6;
	localparam int PHASE_TWO_SOURCE_BIT = 7;
	localparam int TRIPLE_SAMPLE_BIT = 6;
	localparam int PHASE_ONE_LSB = 3;
	localparam int PROPAGATION_LSB = 0;
	localparam int WAKE_FILTER_BIT = 6;
	localparam int PHASE_TWO_LSB = 0;

	// interrupt flag and enable bit positions
	localparam int INT_MSG_ERROR = 7;
	localparam int INT_WAKE = 6;
	localparam int INT_ERROR_CHANGE = 5;
	localparam int INT_TX2_EMPTY = 4;
	localparam int INT_TX1_EMPTY = 3;
	localparam int INT_TX0_EMPTY = 2;
	localparam int INT_RX1_FULL = 1;
	localparam int INT_RX0_FULL = 0;

	// requested_operation encodings
	localparam logic [2:0] OP_NORMAL = 3'h0;
	localparam logic [2:0] OP_SLEEP = 3'h1;
	localparam logic [2:0] OP_LOOPBACK = 3'h2;
	localparam logic [2:0] OP_LISTEN = 3'h3;
	localparam logic [2:0] OP_CONFIG = 3'h4;

	// reset values
	localparam logic [7:0] RST_MAIN_CONTROL = 8'h87;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// time quantum limits
	localparam logic [3:0] PHASE_TWO_MIN_TQ = 4'h2;

	// wake filter length, in clock cycles
	localparam int WAKE_FILTER_CYCLES = 16;

	// operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SLEEP,
		MODE_LOOPBACK,
		MODE_LISTEN,
		MODE_CONFIG
	} op_mode_e;

	// one register access request
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [REG_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

	// decoded bit timing, lengths in time quanta
	typedef struct packed {
		logic [3:0] jump_width;
		logic [3:0] propagation;
		logic [3:0] phase_one;
		logic [3:0] phase_two;
		logic       triple_sample;
	} bit_timing_s;

endpackage : can_cfg_pkg

// file: src/clock_output_pin_divider.sv
// clock-output prescaler: toggles its output every 2**prescale cycles
`timescale 1ns/10ps
module clock_output_pin_divider import can_cfg_pkg::*; (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// setup
	input  wire logic       enable,
	input  wire logic [1:0] prescale,
	// divided clock
	output logic            clk_out
);

	logic [2:0] cnt;       // half-period counter
	logic [2:0] next_cnt;
	logic       next_clk_out;
	logic [2:0] half_last; // last count of a half period

	////////////////////////////////////////////////////////////////////////
	// next count and output level
	always_comb begin
		half_last = 3'(({2'h0, 1'b1} << prescale) - 3'h1);
		next_cnt = cnt;
		next_clk_out = clk_out;
		if (!enable) begin
			// stopped: held low
			next_cnt = 3'h0;
			next_clk_out = 1'b0;
		end else if (cnt >= half_last) begin
			next_cnt = 3'h0;
			next_clk_out = ~clk_out;
		end else begin
			next_cnt = 3'(cnt + 3'h1);
		end
	end

	// register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			clk_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			clk_out <= next_clk_out;
		end
	end

endmodule : clock_output_pin_divider

// file: src/can_controller_setup_regs.sv
// configuration, mode and pin control registers of the CAN controller
// Operation
// - rollover sends message to buffer one
// - buffer-one pin: off, loaded flag, GPIO
// - buffer-zero pin: same three choices
// - request pins readable as plain inputs
// - request pin starts its buffer's transmission
// - requested operation field selects mode
// - clock output disabled or divided oscillator
// - jump width one to four quanta
// - own phase two two to eight quanta
// - phase one one to eight quanta
// - propagation one to eight quanta
// - phase two source: field or max
// - sample once or three times
// - wake noise filter in sleep
// - enable bits 7..5: error, wake, flags
// - enable bits 4..0: tx empty, rx full
// - timing writable only in configuration mode
`timescale 1ns/10ps
module can_controller_setup_regs import can_cfg_pkg::*; #(
	parameter int FILTER_CYCLES = WAKE_FILTER_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port from the serial front end
	input  wire reg_req_s    reg_req,
	output logic [7:0]       reg_rdata,
	output logic             reg_rvalid,
	// protocol engine events
	input  wire logic        rx_msg_accept,
	input  wire logic [4:0]  engine_event,
	output logic [1:0]       rx_load,
	output logic             rx_overflow,
	output logic [2:0]       tx_start,
	// transmit-request pins, active low
	input  wire logic [2:0]  tx_req_pin_n,
	// receive-buffer-full pins: index 1 buf1, index 0 buf0
	output logic [1:0]       rx_buf_full_pin_out,
	output logic [1:0]       rx_buf_full_pin_oe,
	// clock output
	output logic             clock_output_pin,
	// bus receive input and filtered copy
	input  wire logic        can_rx_pin,
	output logic             can_rx_filtered,
	// interrupt and configuration outputs
	output logic             int_n,
	output logic [2:0]       op_mode,
	output bit_timing_s      bit_timing
);

	////////////////////////////////////////////////////////////////////////
	// helper functions

	// field value to length in quanta
	function automatic logic [3:0] tq_len(input logic [2:0] field);
		tq_len = {1'b0, field} + 4'h1;
	endfunction : tq_len

	// mode to its status encoding
	function automatic logic [2:0] mode_code(input op_mode_e m);
		case (m)
			MODE_NORMAL:   mode_code = OP_NORMAL;
			MODE_SLEEP:    mode_code = OP_SLEEP;
			MODE_LOOPBACK: mode_code = OP_LOOPBACK;
			MODE_LISTEN:   mode_code = OP_LISTEN;
			default:       mode_code = OP_CONFIG;
		endcase
	endfunction : mode_code

	////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0] rx_ctrl, pin_ctrl, txr_ctrl, main_ctrl;  // software registers
	logic [7:0] timing1, timing2, timing3, int_mask, int_flags;
	logic [7:0] next_rx_ctrl, next_pin_ctrl, next_txr_ctrl, next_main_ctrl;
	logic [7:0] next_timing1, next_timing2, next_timing3, next_int_mask;
	logic [7:0] next_int_flags;
	op_mode_e   mode, next_mode;                           // current mode
	logic [2:0] txr_meta, txr_sync, txr_prev;              // request pin sync
	logic       rx_meta, rx_sync;                          // receive pin sync
	logic [7:0] next_rdata;
	logic [1:0] next_rx_load, next_pin_out, next_pin_oe;
	logic [2:0] next_tx_start;
	logic       next_overflow, next_int_n, next_rx_filtered;
	logic [7:0] filt_cnt, next_filt_cnt;                   // wake filter count
	bit_timing_s next_timing;
	logic       wr_hit;

	////////////////////////////////////////////////////////////////////////
	// register writes, mode control and interrupt flags
	always_comb begin
		next_rx_ctrl = rx_ctrl;
		next_pin_ctrl = pin_ctrl;
		next_txr_ctrl = txr_ctrl;
		next_main_ctrl = main_ctrl;
		next_timing1 = timing1;
		next_timing2 = timing2;
		next_timing3 = timing3;
		next_int_mask = int_mask;
		next_int_flags = int_flags;
		next_rx_load = 2'h0;
		next_overflow = 1'b0;
		wr_hit = reg_req.wr;
		// software writes
		if (wr_hit) begin
			case (reg_req.addr)
				OFS_RX_BUFFER0_CONTROL: next_rx_ctrl = reg_req.wdata;
				OFS_BUFFER_PIN_CONTROL: next_pin_ctrl = reg_req.wdata;
				// pin levels are read-only
				OFS_TX_REQUEST_PIN_CONTROL: next_txr_ctrl = {5'h00, reg_req.wdata[2:0]};
				OFS_MAIN_CONTROL_REGISTER:  next_main_ctrl = reg_req.wdata;
				OFS_BIT_TIMING_CONFIG_1: begin
					if (mode == MODE_CONFIG) next_timing1 = reg_req.wdata;
				end
				OFS_BIT_TIMING_CONFIG_2: begin
					if (mode == MODE_CONFIG) next_timing2 = reg_req.wdata;
				end
				OFS_BIT_TIMING_CONFIG_3: begin
					if (mode == MODE_CONFIG) next_timing3 = reg_req.wdata;
				end
				OFS_INTERRUPT_ENABLE_MASK: next_int_mask = reg_req.wdata;
				// write one to clear
				OFS_INTERRUPT_FLAGS: next_int_flags = int_flags & ~reg_req.wdata;
				default: ;
			endcase
		end
		if (rx_msg_accept) begin
			if (!int_flags[INT_RX0_FULL]) begin
				next_rx_load = 2'b01;
			end else if (rx_ctrl[RX_ROLLOVER_BIT] && !int_flags[INT_RX1_FULL]) begin
				next_rx_load = 2'b10;
			end else begin
				// no room: message dropped
				next_overflow = 1'b1;
			end
		end
		// events set flags; set wins over a same-cycle clear
		next_int_flags[INT_RX0_FULL] = next_int_flags[INT_RX0_FULL] | next_rx_load[0];
		next_int_flags[INT_RX1_FULL] = next_int_flags[INT_RX1_FULL] | next_rx_load[1];
		next_int_flags[7] = next_int_flags[7] | engine_event[4];
		next_int_flags[5:2] = next_int_flags[5:2] | engine_event[3:0];
		if (mode == MODE_SLEEP && can_rx_filtered && !next_rx_filtered) begin
			next_int_flags[INT_WAKE] = 1'b1;
		end
		case (main_ctrl[REQ_OP_LSB +: 3])
			OP_NORMAL:   next_mode = MODE_NORMAL;
			OP_SLEEP:    next_mode = MODE_SLEEP;
			OP_LOOPBACK: next_mode = MODE_LOOPBACK;
			OP_LISTEN:   next_mode = MODE_LISTEN;
			default:     next_mode = MODE_CONFIG;
		endcase
	end

	// register the control state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_ctrl <= RST_ZERO;
			pin_ctrl <= RST_ZERO;
			txr_ctrl <= RST_ZERO;
			main_ctrl <= RST_MAIN_CONTROL;
			timing1 <= RST_ZERO;
			timing2 <= RST_ZERO;
			timing3 <= RST_ZERO;
			int_mask <= RST_ZERO;
			int_flags <= RST_ZERO;
			mode <= MODE_CONFIG;
			rx_load <= 2'h0;
			rx_overflow <= 1'b0;
		end else begin
			rx_ctrl <= next_rx_ctrl;
			pin_ctrl <= next_pin_ctrl;
			txr_ctrl <= next_txr_ctrl;
			main_ctrl <= next_main_ctrl;
			timing1 <= next_timing1;
			timing2 <= next_timing2;
			timing3 <= next_timing3;
			int_mask <= next_int_mask;
			int_flags <= next_int_flags;
			mode <= next_mode;
			rx_load <= next_rx_load;
			rx_overflow <= next_overflow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two stages each
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txr_meta <= 3'h7;
			txr_sync <= 3'h7;
			txr_prev <= 3'h7;
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			txr_meta <= tx_req_pin_n;
			txr_sync <= txr_meta;
			txr_prev <= txr_sync;
			rx_meta <= can_rx_pin;
			rx_sync <= rx_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wake filter, pins, timing, interrupt and read data
	always_comb begin
		next_filt_cnt = 8'h00;
		next_rx_filtered = rx_sync;
		if (mode == MODE_SLEEP && timing3[WAKE_FILTER_BIT] && rx_sync != can_rx_filtered) begin
			next_rx_filtered = can_rx_filtered;
			next_filt_cnt = 8'(filt_cnt + 8'h01);
			if (filt_cnt >= 8'(FILTER_CYCLES - 1)) begin
				next_rx_filtered = rx_sync;
				next_filt_cnt = 8'h00;
			end
		end
		next_tx_start = 3'h0;
		if (mode != MODE_CONFIG && mode != MODE_SLEEP) begin
			next_tx_start = txr_prev & ~txr_sync & txr_ctrl[TX_REQ_MODE_LSB +: 3];
		end
		next_pin_oe[0] = pin_ctrl[BUF0_PIN_ENABLE_BIT];
		next_pin_out[0] = pin_ctrl[BUF0_PIN_FUNCTION_BIT] ? ~int_flags[INT_RX0_FULL]
			: pin_ctrl[BUF0_PIN_LEVEL_BIT];
		next_pin_oe[1] = pin_ctrl[BUF1_PIN_ENABLE_BIT];
		next_pin_out[1] = pin_ctrl[BUF1_PIN_FUNCTION_BIT] ? ~int_flags[INT_RX1_FULL]
			: pin_ctrl[BUF1_PIN_LEVEL_BIT];
		next_timing.jump_width = tq_len({1'b0, timing1[JUMP_WIDTH_LSB +: 2]});
		next_timing.propagation = tq_len(timing2[PROPAGATION_LSB +: 3]);
		next_timing.phase_one = tq_len(timing2[PHASE_ONE_LSB +: 3]);
		if (timing2[PHASE_TWO_SOURCE_BIT]) begin
			next_timing.phase_two = tq_len(timing3[PHASE_TWO_LSB +: 3]);
			if (next_timing.phase_two < PHASE_TWO_MIN_TQ) next_timing.phase_two = PHASE_TWO_MIN_TQ;
		end else if (next_timing.phase_one > PHASE_TWO_MIN_TQ) begin
			next_timing.phase_two = next_timing.phase_one;
		end else begin
			next_timing.phase_two = PHASE_TWO_MIN_TQ;
		end
		next_timing.triple_sample = timing2[TRIPLE_SAMPLE_BIT];
		next_int_n = ~|(int_flags & int_mask);
		// read mux
		next_rdata = 8'h00;
		case (reg_req.addr)
			OFS_RX_BUFFER0_CONTROL:     next_rdata = rx_ctrl;
			OFS_BUFFER_PIN_CONTROL:     next_rdata = pin_ctrl;
			OFS_TX_REQUEST_PIN_CONTROL: next_rdata = {2'h0, ~txr_sync, txr_ctrl[2:0]};
			OFS_MAIN_CONTROL_REGISTER:  next_rdata = main_ctrl;
			OFS_MODE_STATUS:            next_rdata = {mode_code(mode), 5'h00};
			OFS_BIT_TIMING_CONFIG_1:    next_rdata = timing1;
			OFS_BIT_TIMING_CONFIG_2:    next_rdata = timing2;
			OFS_BIT_TIMING_CONFIG_3:    next_rdata = timing3;
			OFS_INTERRUPT_ENABLE_MASK:  next_rdata = int_mask;
			OFS_INTERRUPT_FLAGS:        next_rdata = int_flags;
			default:                    next_rdata = 8'h00;
		endcase
	end

	// register pins and outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			filt_cnt <= 8'h00;
			can_rx_filtered <= 1'b1;
			tx_start <= 3'h0;
			rx_buf_full_pin_out <= 2'h0;
			rx_buf_full_pin_oe <= 2'h0;
			bit_timing <= '0;
			int_n <= 1'b1;
			op_mode <= OP_CONFIG;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			filt_cnt <= next_filt_cnt;
			can_rx_filtered <= next_rx_filtered;
			tx_start <= next_tx_start;
			rx_buf_full_pin_out <= next_pin_out;
			rx_buf_full_pin_oe <= next_pin_oe;
			bit_timing <= next_timing;
			int_n <= next_int_n;
			op_mode <= mode_code(mode);
			reg_rdata <= reg_req.rd ? next_rdata : reg_rdata;
			reg_rvalid <= reg_req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock output prescaler
	clock_output_pin_divider u_clock_output_pin (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.enable   (main_ctrl[CLK_OUT_ENABLE_BIT]),
		.prescale (main_ctrl[CLK_OUT_PRESCALE_LSB +: 2]),
		.clk_out  (clock_output_pin)
	);

endmodule : can_controller_setup_regs

// file: testbench/reg_host.sv
// host model that drives the register port of the setup block
`timescale 1ns/10ps
module reg_host import can_cfg_pkg::*; (
	// clock
	input  wire logic       ref_clk,
	// read data from the block
	input  wire logic [7:0] reg_rdata,
	// request to the block
	output reg_req_s        reg_req
);
	// link already set up
	// serial rate, mode and sample point live in the front end; bytes arrive whole
	// idle request at time zero
	initial begin
		reg_req = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// whole byte writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge ref_clk);
		// released lines show the inverse, not a stale copy
		reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr

	// one read, data taken the cycle after the request
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge ref_clk);
		d = reg_rdata;
		reg_req = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
	endtask : rd
endmodule : reg_host

// file: testbench/can_setup_assertions.sv
// concurrent checks on the ports of the setup register block
`timescale 1ns/10ps
module can_setup_assertions import can_cfg_pkg::*; #(
	parameter int FILTER_CYCLES = WAKE_FILTER_CYCLES
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register port
	input wire reg_req_s    reg_req,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	// engine side
	input wire logic        rx_msg_accept,
	input wire logic [4:0]  engine_event,
	input wire logic [1:0]  rx_load,
	input wire logic        rx_overflow,
	input wire logic [2:0]  tx_start,
	// pins
	input wire logic [2:0]  tx_req_pin_n,
	input wire logic [1:0]  rx_buf_full_pin_out,
	input wire logic [1:0]  rx_buf_full_pin_oe,
	input wire logic        clock_output_pin,
	input wire logic        can_rx_pin,
	input wire logic        can_rx_filtered,
	// status
	input wire logic        int_n,
	input wire logic [2:0]  op_mode,
	input wire bit_timing_s bit_timing
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// shadow of the enable mask, followed from host writes
	logic [7:0] mask_copy;
	logic [7:0] next_mask_copy;
	always_comb begin
		next_mask_copy = mask_copy;
		if (reg_req.wr && reg_req.addr == OFS_INTERRUPT_ENABLE_MASK) begin
			next_mask_copy = reg_req.wdata;
		end
	end
	// register the shadow
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_copy <= RST_ZERO;
		end else begin
			mask_copy <= next_mask_copy;
		end
	end

	// steps of a mode request and a transmit start
	sequence s_mode_req;
		reg_req.wr && reg_req.addr == OFS_MAIN_CONTROL_REGISTER && reg_req.wdata[7:5] < 3'h5;
	endsequence
	sequence s_tx_go;
		tx_start != 3'h0;
	endsequence

	////////////////////////////////////////////////////////////////////////
	a_read_valid: assert property (1 |=> reg_rvalid == $past(reg_req.rd))
		else $error("read valid not one cycle after read");
	a_load_one_hot: assert property (rx_msg_accept |=> $countones({rx_load, rx_overflow}) == 1)
		else $error("accepted message not placed once");
	a_load_idle: assert property (!rx_msg_accept |=> rx_load == 2'b00 && !rx_overflow)
		else $error("load without accepted message");
	a_int_masked: assert property ((mask_copy == 8'h00) [*4] |-> int_n)
		else $error("interrupt with all sources disabled");
	a_mode_follow: assert property (s_mode_req |-> ##3 op_mode == $past(reg_req.wdata[7:5], 3))
		else $error("mode does not follow request");
	a_timing_locked: assert property (!$stable(bit_timing) |->
		op_mode == OP_CONFIG || $past(op_mode) == OP_CONFIG)
		else $error("bit timing changed outside configuration");
	a_tx_start_mode: assert property (s_tx_go |-> op_mode != OP_CONFIG && op_mode != OP_SLEEP)
		else $error("transmit start in config or sleep");
	a_tx_start_cause: assert property (s_tx_go |-> (tx_start & $past(tx_req_pin_n, 3)) == 3'h0)
		else $error("transmit start without low request pin");
	a_jump_range: assert property (bit_timing.jump_width != 4'h0 |-> bit_timing.jump_width <= 4'h4)
		else $error("jump width above four");
	a_seg_range: assert property (bit_timing.phase_one <= 4'h8 && bit_timing.propagation <= 4'h8)
		else $error("segment above eight");
	a_phase2_range: assert property (bit_timing.phase_two != 4'h0 |->
		bit_timing.phase_two inside {[4'h2:4'h8]})
		else $error("phase two out of range");
endmodule : can_setup_assertions

bind can_controller_setup_regs can_setup_assertions #(.FILTER_CYCLES(FILTER_CYCLES))
	i_can_setup_assertions (.ref_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .rx_msg_accept,
	.engine_event, .rx_load, .rx_overflow, .tx_start, .tx_req_pin_n, .rx_buf_full_pin_out,
	.rx_buf_full_pin_oe, .clock_output_pin, .can_rx_pin, .can_rx_filtered, .int_n, .op_mode,
	.bit_timing);

// file: testbench/can_controller_setup_regs_tb.sv
// self-checking bench for the setup register block
`timescale 1ns/10ps
module can_controller_setup_regs_tb import can_cfg_pkg::*;;
	logic        ref_clk = 1'b0;        // bench clock
	logic        rst = 1'b1;            // reset, held at start
	reg_req_s    reg_req;               // from the host model
	logic [7:0]  reg_rdata;             // read data
	logic        rvalid;                // read valid pulse
	logic        rx_msg_accept = 1'b0;  // engine accept pulse
	logic [4:0]  engine_event = 5'h00;  // engine event pulses
	logic [1:0]  rx_load;               // buffer load pulses
	logic        rx_overflow;           // dropped message
	logic [2:0]  tx_start;              // transmit starts
	logic [2:0]  tx_req_pin_n = 3'h7;   // request pins, idle high
	logic [1:0]  pin_out;               // buffer pin levels
	logic [1:0]  pin_oe;                // buffer pin enables
	logic        clk_pin;               // clock output
	logic        can_rx_pin = 1'b1;     // bus receive, recessive
	logic        rx_filt;               // filtered receive
	logic        int_n;                 // interrupt, active low
	logic [2:0]  op_mode;               // current mode
	bit_timing_s bit_timing;            // decoded timing
	logic [7:0]  rd_val;                // last read value
	int          err_total = 0;         // mismatches
	int          cmp_count = 0;         // comparisons
	int          n;                     // measured half period
	int          pos [5] = '{2, 3, 4, 5, 7};  // flag bit of each engine event
	logic [7:0]  c2 [4] = '{8'hBF, 8'h40, 8'h98, 8'h18};  // timing cases
	logic [7:0]  c3 [4] = '{8'h07, 8'h07, 8'h00, 8'h00};
	logic [7:0]  p2 [4] = '{8'h08, 8'h02, 8'h02, 8'h04};  // phase two wanted

	// free-running clock, 10 ns
	always #5 ref_clk = ~ref_clk;

	can_controller_setup_regs #(.FILTER_CYCLES(2)) i_can_controller_setup_regs (
		.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(rvalid), .rx_msg_accept(rx_msg_accept), .engine_event(engine_event),
		.rx_load(rx_load), .rx_overflow(rx_overflow), .tx_start(tx_start),
		.tx_req_pin_n(tx_req_pin_n), .rx_buf_full_pin_out(pin_out), .rx_buf_full_pin_oe(pin_oe),
		.clock_output_pin(clk_pin), .can_rx_pin(can_rx_pin), .can_rx_filtered(rx_filt),
		.int_n(int_n), .op_mode(op_mode), .bit_timing(bit_timing));
	reg_host i_reg_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// wait falling edges
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	// one-cycle engine pulse, rx_load and rx_overflow settled on return
	task automatic ev(input logic acc, input logic [4:0] e);
		@(negedge ref_clk);
		rx_msg_accept = acc;
		engine_event = e;
		@(negedge ref_clk);
		rx_msg_accept = 1'b0;
		engine_event = 5'h00;
	endtask : ev
	// half period of the clock output in cycles
	task automatic per(output int k);
		logic v;
		cyc(3);
		v = clk_pin;
		for (k = 0; k < 40 && clk_pin === v; k++) cyc(1);
		v = clk_pin;
		for (k = 0; k < 40 && clk_pin === v; k++) cyc(1);
	endtask : per
	// pull one request pin low and look for its start
	task automatic txp(input int i, input logic exp);
		logic hit;
		hit = 1'b0;
		tx_req_pin_n[i] = 1'b0;
		repeat (8) begin
			cyc(1);
			if (tx_start[i] === 1'b1) hit = 1'b1;
		end
		chk("tx start", 8'(hit), 8'(exp));
		i_reg_host.rd(OFS_TX_REQUEST_PIN_CONTROL, rd_val);
		chk("pin level", 8'(rd_val[5:3]), 8'(3'h1 << i));
		tx_req_pin_n[i] = 1'b1;
		cyc(4);
	endtask : txp
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	// watchdog, far beyond the expected run
	initial begin
		#100000;
		err_total++;
		summarize();
	end

	// main sequence
	initial begin
		cyc(10);
		rst = 1'b0;
		i_reg_host.rd(OFS_MAIN_CONTROL_REGISTER, rd_val);
		chk("main control", rd_val, RST_MAIN_CONTROL);
		chk("read valid", 8'(rvalid), 8'h01);
		i_reg_host.rd(OFS_INTERRUPT_ENABLE_MASK, rd_val);
		chk("enable mask", rd_val, RST_ZERO);
		i_reg_host.rd(8'h0A, rd_val);
		chk("unmapped", rd_val, 8'h00);
		chk("mode", 8'(op_mode), 8'(OP_CONFIG));
		chk("pin oe", 8'(pin_oe), 8'h00);
		done("reset");
		for (int j = 0; j < 4; j++) begin
			i_reg_host.wr(OFS_BIT_TIMING_CONFIG_1, {2'(j), 6'h00});
			cyc(2);
			chk("jump", 8'(bit_timing.jump_width), 8'(j + 1));
		end
		for (int i = 0; i < 4; i++) begin
			i_reg_host.wr(OFS_BIT_TIMING_CONFIG_2, c2[i]);
			i_reg_host.wr(OFS_BIT_TIMING_CONFIG_3, c3[i]);
			cyc(2);
			chk("ph2", 8'(bit_timing.phase_two), p2[i]);
			chk("ph1", 8'(bit_timing.phase_one), {5'h00, c2[i][5:3]} + 8'h01);
			chk("prop", 8'(bit_timing.propagation), {5'h00, c2[i][2:0]} + 8'h01);
			chk("sample", 8'(bit_timing.triple_sample), 8'(c2[i][6]));
		end
		done("timing");
		i_reg_host.wr(OFS_RX_BUFFER0_CONTROL, 8'h04);
		i_reg_host.wr(OFS_INTERRUPT_ENABLE_MASK, 8'h02);
		i_reg_host.wr(OFS_BUFFER_PIN_CONTROL, 8'h0F);
		ev(1'b1, 5'h00);
		chk("load", {5'h00, rx_overflow, rx_load}, 8'h01);
		cyc(2);
		chk("int", 8'(int_n), 8'h01);
		chk("pins", {4'h0, pin_oe, pin_out}, 8'h0E);
		ev(1'b1, 5'h00);
		chk("load", {5'h00, rx_overflow, rx_load}, 8'h02);
		cyc(2);
		chk("int", 8'(int_n), 8'h00);
		chk("pins", {4'h0, pin_oe, pin_out}, 8'h0C);
		ev(1'b1, 5'h00);
		chk("load", {5'h00, rx_overflow, rx_load}, 8'h04);
		i_reg_host.wr(OFS_INTERRUPT_FLAGS, 8'h03);
		i_reg_host.wr(OFS_RX_BUFFER0_CONTROL, 8'h00);
		ev(1'b1, 5'h00);
		ev(1'b1, 5'h00);
		chk("no rollover", {5'h00, rx_overflow, rx_load}, 8'h04);
		i_reg_host.wr(OFS_BUFFER_PIN_CONTROL, 8'h3C);
		cyc(2);
		chk("gpio high", {4'h0, pin_oe, pin_out}, 8'h0F);
		i_reg_host.wr(OFS_BUFFER_PIN_CONTROL, 8'h0C);
		cyc(2);
		chk("gpio low", {4'h0, pin_oe, pin_out}, 8'h0C);
		i_reg_host.wr(OFS_BUFFER_PIN_CONTROL, 8'h00);
		cyc(2);
		chk("high z", 8'(pin_oe), 8'h00);
		i_reg_host.wr(OFS_INTERRUPT_FLAGS, 8'hFF);
		done("receive");
		for (int i = 0; i < 5; i++) begin
			i_reg_host.wr(OFS_INTERRUPT_ENABLE_MASK, 8'h01 << pos[i]);
			ev(1'b0, 5'h01 << i);
			cyc(2);
			chk("event int", 8'(int_n), 8'h00);
			i_reg_host.rd(OFS_INTERRUPT_FLAGS, rd_val);
			chk("event flag", rd_val, 8'h01 << pos[i]);
			i_reg_host.wr(OFS_INTERRUPT_FLAGS, 8'hFF);
			cyc(2);
			chk("int clear", 8'(int_n), 8'h01);
		end
		done("events");
		for (int p = 0; p < 4; p++) begin
			i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {OP_CONFIG, 3'h1, 2'(p)});
			per(n);
			chk("clock_output_pin", 8'(n), 8'(1 << p));
		end
		i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {OP_CONFIG, 5'h00});
		per(n);
		chk("clock_output_pin off", 8'(n), 8'h28);
		done("clock");
		for (int m = 0; m < 5; m++) begin
			i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {3'(m), 5'h07});
			cyc(3);
			chk("op mode", 8'(op_mode), 8'(m));
			i_reg_host.rd(OFS_MODE_STATUS, rd_val);
			chk("status", 8'(rd_val[7:5]), 8'(m));
		end
		i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {OP_NORMAL, 5'h07});
		cyc(3);
		i_reg_host.wr(OFS_BIT_TIMING_CONFIG_1, 8'h00);
		cyc(2);
		chk("locked", 8'(bit_timing.jump_width), 8'h04);
		done("modes");
		i_reg_host.wr(OFS_TX_REQUEST_PIN_CONTROL, 8'h07);
		for (int i = 0; i < 3; i++) txp(i, 1'b1);
		i_reg_host.wr(OFS_TX_REQUEST_PIN_CONTROL, 8'h00);
		txp(1, 1'b0);
		done("requests");
		i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {OP_CONFIG, 5'h07});
		cyc(3);
		i_reg_host.wr(OFS_BIT_TIMING_CONFIG_3, 8'h40);
		i_reg_host.wr(OFS_INTERRUPT_ENABLE_MASK, 8'h40);
		i_reg_host.wr(OFS_MAIN_CONTROL_REGISTER, {OP_SLEEP, 5'h07});
		cyc(3);
		can_rx_pin = 1'b0;
		cyc(1);
		can_rx_pin = 1'b1;
		cyc(6);
		chk("glitch", 8'(int_n), 8'h01);
		can_rx_pin = 1'b0;
		cyc(8);
		chk("filtered", 8'(rx_filt), 8'h00);
		chk("wake int", 8'(int_n), 8'h00);
		can_rx_pin = 1'b1;
		done("wake");
		summarize();
	end
endmodule : can_controller_setup_regs_tb
